// file: verilog/tsms_pkg.sv
// =====================================================================
// shared constants of the mode-switch command block
package tsms_pkg;

   // =====================================================================
   // command and pointer bytes
   localparam logic [7:0] CMD_START_CONV = 8'h51;
   localparam logic [7:0] CMD_HALT_CONV  = 8'h22;
   localparam logic [7:0] CMD_COMMIT_NV  = 8'h48;
   localparam logic [7:0] PTR_CFG_MSB    = 8'hAC;

   // =====================================================================
   // link framing
   localparam logic       RW_WRITE       = 1'b0;
   localparam logic [6:0] DEV_ADDR_RESET = 7'h48;
   localparam logic [2:0] BIT_LAST       = 3'h7;

   // =====================================================================
   // configuration byte
   localparam int         SINGLE_BIT     = 0;
   localparam logic [7:0] CFG_MSB_RESET  = 8'h00;

   // =====================================================================
   // timing
   localparam int CLK_FREQ_KHZ       = 10000;
   localparam int COPY_TIME_US       = 10000;
   localparam int COPY_CYCLES        = (COPY_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
   localparam int CONV_CYCLES_RESET  = 2000;

   // =====================================================================
   // link receiver states
   typedef enum logic [2:0] {
      LK_IDLE,
      LK_ADDR,
      LK_CMD,
      LK_DATA,
      LK_SKIP
   } tsms_link_state_t;

endpackage

// file: verilog/tsms_nvstore.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// volatile shadow of the configuration byte and its nonvolatile copy
module tsms_nvstore #(
   parameter int COPY_CYCLES = tsms_pkg::COPY_CYCLES
) (
   // system
   input  wire logic       clk,
   input  wire logic       rstn,
   // write and commit requests
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   input  wire logic       commit,
   // stored contents
   output logic [7:0]      sram_q,
   output logic [7:0]      nv_q,
   output logic            busy_q
);

   localparam int BW = $clog2(COPY_CYCLES + 1);
   localparam logic [BW-1:0] BUSY_LAST = BW'(COPY_CYCLES - 1);

   logic [BW-1:0] busy_cnt_q;

   // =====================================================================
   // volatile shadow, written by the pointer path only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sram_q <= tsms_pkg::CFG_MSB_RESET;
      end else if (wr_en) begin
         sram_q <= wr_data;
      end
   end

   // =====================================================================
   // nonvolatile image changes only on commit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nv_q <= tsms_pkg::CFG_MSB_RESET;
      end else if (commit) begin
         nv_q <= sram_q;
      end
   end

   // =====================================================================
   // busy while the copy is being programmed; a new commit restarts it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy_q     <= 1'b0;
         busy_cnt_q <= '0;
      end else if (commit) begin
         busy_q     <= 1'b1;
         busy_cnt_q <= '0;
      end else if (busy_q) begin
         if (busy_cnt_q == BUSY_LAST) begin
            busy_q <= 1'b0;
         end
         busy_cnt_q <= busy_cnt_q + BW'(1);
      end
   end

endmodule // tsms_nvstore
`default_nettype wire

// file: verilog/tsms_sensor_cmd.sv
`timescale 1ns/1ns
`default_nettype none
module tsms_sensor_cmd #(
   parameter logic [6:0] DEV_ADDR    = tsms_pkg::DEV_ADDR_RESET,
   parameter int         CONV_CYCLES = tsms_pkg::CONV_CYCLES_RESET,
   parameter int         COPY_CYCLES = tsms_pkg::COPY_CYCLES
) (
   // system
   input  wire logic       clk,
   input  wire logic       rstn,
   // 2-wire link, scl is the link clock
   input  wire logic       scl,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   // conversion engine
   output logic            conv_run,
   output logic            conv_done,
   // configuration state
   output logic            single_conversion_select,
   output logic            nonvolatile_busy_flag,
   output logic [7:0]      cfg_msb,
   output logic [7:0]      nv_cfg_msb
);

   localparam int CW = $clog2(CONV_CYCLES + 1);
   localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

   // =====================================================================
   // link side: sda sampled at the rising scl edge, acted on at the falling
   tsms_pkg::tsms_link_state_t lk_state_q;
   logic       sda_rise_q;
   logic [6:0] shift_q;
   logic [2:0] bit_q;
   logic       ack_phase_q;
   logic       sda_oe_q;
   logic [7:0] ev_data_q;
   logic       ev_kind_q;
   logic       ev_tog_q;
   logic       start_seen;
   logic       byte_end;
   logic [7:0] rx_byte;

   assign start_seen = sda_rise_q & ~sda_i;
   assign byte_end   = (bit_q == tsms_pkg::BIT_LAST) && !ack_phase_q;
   assign rx_byte    = {shift_q, sda_rise_q};

   always_ff @(posedge scl or negedge rstn) begin
      if (!rstn) begin
         sda_rise_q <= 1'b1;
      end else begin
         sda_rise_q <= sda_i;
      end
   end

   // framing and byte receive
   always_ff @(negedge scl or negedge rstn) begin
      if (!rstn) begin
         lk_state_q  <= tsms_pkg::LK_IDLE;
         shift_q     <= '0;
         bit_q       <= '0;
         ack_phase_q <= 1'b0;
      end else if (start_seen) begin
         lk_state_q  <= tsms_pkg::LK_ADDR;
         bit_q       <= '0;
         ack_phase_q <= 1'b0;
      end else if (lk_state_q != tsms_pkg::LK_IDLE) begin
         if (ack_phase_q) begin
            ack_phase_q <= 1'b0;
            bit_q       <= '0;
         end else begin
            shift_q <= rx_byte[6:0];
            bit_q   <= bit_q + 3'h1;
         end
         if (byte_end) begin
            ack_phase_q <= 1'b1;
            case (lk_state_q)
               tsms_pkg::LK_ADDR: begin
                  if (rx_byte == {DEV_ADDR, tsms_pkg::RW_WRITE}) begin
                     lk_state_q <= tsms_pkg::LK_CMD;
                  end else begin
                     lk_state_q  <= tsms_pkg::LK_IDLE;
                     ack_phase_q <= 1'b0;
                  end
               end
               tsms_pkg::LK_CMD: begin
                  if (rx_byte == tsms_pkg::PTR_CFG_MSB) begin
                     lk_state_q <= tsms_pkg::LK_DATA;
                  end else begin
                     lk_state_q <= tsms_pkg::LK_SKIP;
                  end
               end
               default: begin
                  lk_state_q <= tsms_pkg::LK_SKIP;
               end
            endcase
         end
      end
   end

   // acknowledge drive for one bit time
   always_ff @(negedge scl or negedge rstn) begin
      if (!rstn) begin
         sda_oe_q <= 1'b0;
      end else if (start_seen || sda_oe_q) begin
         sda_oe_q <= 1'b0;
      end else if (byte_end && lk_state_q != tsms_pkg::LK_IDLE) begin
         sda_oe_q <= (lk_state_q != tsms_pkg::LK_ADDR) ||
                     (rx_byte == {DEV_ADDR, tsms_pkg::RW_WRITE});
      end
   end

   // hand each command or data byte across with a toggle
   always_ff @(negedge scl or negedge rstn) begin
      if (!rstn) begin
         ev_data_q <= '0;
         ev_kind_q <= 1'b0;
         ev_tog_q  <= 1'b0;
      end else if (!start_seen && byte_end &&
                   (lk_state_q == tsms_pkg::LK_CMD || lk_state_q == tsms_pkg::LK_DATA)) begin
         ev_data_q <= rx_byte;
         ev_kind_q <= (lk_state_q == tsms_pkg::LK_DATA);
         ev_tog_q  <= ~ev_tog_q;
      end
   end

   assign sda_oe = sda_oe_q;

   always_ff @(posedge scl or negedge rstn) begin
      if (!rstn) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   // =====================================================================
   // system side: toggle synchroniser and command decode
   logic tog_s1_q;
   logic tog_s2_q;
   logic tog_s3_q;
   logic ev;
   logic cmd_start;
   logic cmd_halt;
   logic cmd_commit;
   logic cfg_wr;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tog_s1_q <= 1'b0;
         tog_s2_q <= 1'b0;
         tog_s3_q <= 1'b0;
      end else begin
         tog_s1_q <= ev_tog_q;
         tog_s2_q <= tog_s1_q;
         tog_s3_q <= tog_s2_q;
      end
   end

   // ev_data_q and ev_kind_q are stable for a whole byte time around ev
   assign ev         = tog_s2_q ^ tog_s3_q;
   assign cmd_start  = ev && !ev_kind_q && (ev_data_q == tsms_pkg::CMD_START_CONV);
   assign cmd_halt   = ev && !ev_kind_q && (ev_data_q == tsms_pkg::CMD_HALT_CONV);
   assign cmd_commit = ev && !ev_kind_q && (ev_data_q == tsms_pkg::CMD_COMMIT_NV);
   assign cfg_wr     = ev && ev_kind_q;

   // =====================================================================
   // configuration shadow and nonvolatile copy
   tsms_nvstore #(
      .COPY_CYCLES (COPY_CYCLES)
   ) u_nvstore (
      .clk     (clk),
      .rstn    (rstn),
      .wr_en   (cfg_wr),
      .wr_data (ev_data_q),
      .commit  (cmd_commit),
      .sram_q  (cfg_msb),
      .nv_q    (nv_cfg_msb),
      .busy_q  (nonvolatile_busy_flag)
   );

   assign single_conversion_select = cfg_msb[tsms_pkg::SINGLE_BIT];

   // =====================================================================
   // conversion engine
   logic [CW-1:0] conv_cnt_q;
   logic          conv_end;

   assign conv_end = conv_run && (conv_cnt_q == CONV_LAST);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         conv_run   <= 1'b0;
         conv_cnt_q <= '0;
      end else if (cmd_halt) begin
         conv_run   <= 1'b0;
         conv_cnt_q <= '0;
      end else if (cmd_start && !conv_run) begin
         conv_run   <= 1'b1;
         conv_cnt_q <= '0;
      end else if (conv_end) begin
         conv_run   <= !single_conversion_select;
         conv_cnt_q <= '0;
      end else if (conv_run) begin
         conv_cnt_q <= conv_cnt_q + CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         conv_done <= 1'b0;
      end else begin
         conv_done <= conv_end && !cmd_halt;
      end
   end

   // =====================================================================
   // checks
   chk_ack_address: assert property (@(negedge scl) disable iff (!rstn)
      (lk_state_q == tsms_pkg::LK_ADDR && byte_end && !start_seen && !sda_oe_q &&
       rx_byte == {DEV_ADDR, tsms_pkg::RW_WRITE}) |=> sda_oe_q ##1 !sda_oe_q)
      else $error("address byte not acknowledged for one bit");

   chk_ack_data_byte: assert property (@(negedge scl) disable iff (!rstn)
      (lk_state_q inside {tsms_pkg::LK_CMD, tsms_pkg::LK_DATA} && byte_end &&
       !start_seen && !sda_oe_q) |=> sda_oe_q && ev_tog_q != $past(ev_tog_q))
      else $error("written byte not acknowledged or not forwarded");

   chk_start_conv: assert property (@(posedge clk) disable iff (!rstn)
      (cmd_start && !conv_run && !cmd_halt) |=> conv_run && conv_cnt_q == '0)
      else $error("start command did not begin conversion");

   chk_halt_conv: assert property (@(posedge clk) disable iff (!rstn)
      cmd_halt |=> !conv_run ##1 (!conv_done))
      else $error("halt command did not stop conversion");

   chk_cfg_shadow: assert property (@(posedge clk) disable iff (!rstn)
      cfg_wr |=> cfg_msb == $past(ev_data_q) && nv_cfg_msb == $past(nv_cfg_msb))
      else $error("config write wrong or reached nonvolatile copy");

   chk_mode_bit: assert property (@(posedge clk) disable iff (!rstn)
      cfg_wr |=> single_conversion_select == $past(ev_data_q[tsms_pkg::SINGLE_BIT]))
      else $error("mode bit does not follow written bit0");

   chk_commit_busy: assert property (@(posedge clk) disable iff (!rstn)
      cmd_commit |=> nonvolatile_busy_flag && nv_cfg_msb == $past(cfg_msb))
      else $error("commit did not copy shadow or raise busy");

   chk_single_once: assert property (@(posedge clk) disable iff (!rstn)
      (conv_end && single_conversion_select && !cmd_halt) |=> !conv_run && conv_done)
      else $error("single mode did not stop after one conversion");

   chk_cont_repeat: assert property (@(posedge clk) disable iff (!rstn)
      (conv_end && !single_conversion_select && !cmd_halt) |=> conv_run && conv_done)
      else $error("continuous mode stopped without halt");

   chk_addr_refused: assert property (@(negedge scl) disable iff (!rstn)
      (lk_state_q == tsms_pkg::LK_ADDR && byte_end && !start_seen &&
       rx_byte != {DEV_ADDR, tsms_pkg::RW_WRITE}) |=> !sda_oe_q && lk_state_q == tsms_pkg::LK_IDLE)
      else $error("foreign or read address was acknowledged");

   chk_ptr_to_data: assert property (@(negedge scl) disable iff (!rstn)
      (lk_state_q == tsms_pkg::LK_CMD && byte_end && !start_seen &&
       rx_byte == tsms_pkg::PTR_CFG_MSB) |=> lk_state_q == tsms_pkg::LK_DATA)
      else $error("pointer byte did not select the config byte");

   chk_nv_untouched: assert property (@(posedge clk) disable iff (!rstn)
      !cmd_commit |=> nv_cfg_msb == $past(nv_cfg_msb))
      else $error("nonvolatile copy changed without commit");

   // cycles since the last commit, saturating just past the copy time
   localparam int BCW = $clog2(COPY_CYCLES + 2);
   logic [BCW-1:0] busy_age_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy_age_q <= '0;
      end else if (cmd_commit) begin
         busy_age_q <= '0;
      end else if (busy_age_q <= BCW'(COPY_CYCLES)) begin
         busy_age_q <= busy_age_q + BCW'(1);
      end
   end

   chk_busy_holds: assert property (@(posedge clk) disable iff (!rstn)
      (nonvolatile_busy_flag && busy_age_q < BCW'(COPY_CYCLES - 1)) |=> nonvolatile_busy_flag)
      else $error("busy flag dropped before the copy time");

   chk_busy_span: assert property (@(posedge clk) disable iff (!rstn)
      nonvolatile_busy_flag |-> busy_age_q < BCW'(COPY_CYCLES))
      else $error("busy flag outlived the copy time");

   cov_start: cover property (@(posedge clk) disable iff (!rstn) cmd_start ##1 conv_run);
   cov_single: cover property (@(posedge clk) disable iff (!rstn)
      cfg_wr && ev_data_q[tsms_pkg::SINGLE_BIT]);
   cov_commit: cover property (@(posedge clk) disable iff (!rstn) cmd_commit);
   cov_halt: cover property (@(posedge clk) disable iff (!rstn) conv_run ##1 cmd_halt);

endmodule // tsms_sensor_cmd
`default_nettype wire

// file: testbench/tsms_bus_master.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// 2-wire bus master model; scl stands high outside frames
module tsms_bus_master (
   // link
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   // =====================================================================
   // start and repeated start: sda falls while scl is high
   task automatic start();
      scl     = 1'b0;
      sda_low = 1'b0;
      #31 scl = 1'b1;
      #31 sda_low = 1'b1;
      #32 scl = 1'b0;
      #31;
   endtask

   // =====================================================================
   // one byte msb first, then the ack slot with sda released
   task automatic put(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low = ~b[i];
         #31 scl = 1'b1;
         #63 scl = 1'b0;
         #31;
      end
      sda_low = 1'b0;
      #31 scl = 1'b1;
      #31 ack = sda;
      #32 scl = 1'b0;
      #31;
   endtask

   // =====================================================================
   // stop: sda rises while scl is high
   task automatic stop();
      sda_low = 1'b1;
      #31 scl = 1'b1;
      #31 sda_low = 1'b0;
      #63;
   endtask
endmodule // tsms_bus_master
`default_nettype wire

// file: testbench/test_thermo_sensor_mode_switch_cmds.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_thermo_sensor_mode_switch_cmds;
   localparam int CONV = 10;
   localparam int COPY = 20;
   logic       clk, rstn, scl, sda_low, sda_o, sda_oe, conv_run, conv_done, single, busy, ak;
   logic [7:0] cfg_msb, nv_cfg_msb, prev_cfg, data, want;
   wire logic  sda;
   int         err_count, checked, done_cnt, seed, n;
   logic [7:0] exp_q[$];

   // pull-up wire: low when either party pulls it
   assign sda = ~(sda_low | (sda_oe & ~sda_o));

   initial clk = 1'b0;
   always #50 clk = ~clk;

   tsms_sensor_cmd #(.CONV_CYCLES(CONV), .COPY_CYCLES(COPY)) tsms_sensor_cmd_i (
      .clk(clk), .rstn(rstn), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .conv_run(conv_run), .conv_done(conv_done), .single_conversion_select(single),
      .nonvolatile_busy_flag(busy), .cfg_msb(cfg_msb), .nv_cfg_msb(nv_cfg_msb));

   tsms_bus_master tsms_bus_master_i (.scl(scl), .sda_low(sda_low), .sda(sda));

   // =====================================================================
   // watchers: conversion count and shadow byte updates against notes
   initial done_cnt = 0;
   always @(posedge clk) if (conv_done === 1'b1) done_cnt++;

   initial prev_cfg = 8'h00;
   always @(posedge clk) begin
      if (rstn === 1'b1 && cfg_msb !== prev_cfg) begin
         want = (exp_q.size() == 0) ? prev_cfg : exp_q.pop_front();
         `CHK("cfg_msb", want, cfg_msb)
      end
      prev_cfg = cfg_msb;
   end

   // =====================================================================
   // transactions
   task automatic cmd(input logic [7:0] b0, input logic two, input logic [7:0] b1);
      tsms_bus_master_i.start();
      tsms_bus_master_i.put({tsms_pkg::DEV_ADDR_RESET, tsms_pkg::RW_WRITE}, ak);
      `CHK("addr ack", 1'b0, ak)
      tsms_bus_master_i.put(b0, ak);
      `CHK("byte ack", 1'b0, ak)
      if (two) begin
         tsms_bus_master_i.put(b1, ak);
         `CHK("data ack", 1'b0, ak)
      end
      repeat (6) @(posedge clk);
   endtask

   task automatic set_mode(input logic one);
      logic [7:0] old;
      old = nv_cfg_msb;
      data = 8'($random(seed));
      data[tsms_pkg::SINGLE_BIT] = one;
      exp_q.push_back(data);
      cmd(tsms_pkg::PTR_CFG_MSB, 1'b1, data);
      `CHK("single", one, single)
      `CHK("nv kept", old, nv_cfg_msb)
   endtask

   task automatic commit();
      cmd(tsms_pkg::CMD_COMMIT_NV, 1'b0, 8'h00);
      `CHK("busy", 1'b1, busy)
      `CHK("nv copy", data, nv_cfg_msb)
      n = 0;
      while (busy === 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      `CHK("copy time", 1'b1, n >= 1 && n <= COPY)
   endtask

   task automatic close_out();
      if (err_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #1_000_000;
      err_count++;
      close_out();
   end

   // =====================================================================
   // main sequence
   initial begin
      seed = 6;
      rstn = 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      `CHK("reset state", 4'h0, {conv_run, busy, single, sda_oe})
      tsms_bus_master_i.start();
      tsms_bus_master_i.put({7'h49, tsms_pkg::RW_WRITE}, ak);
      `CHK("foreign addr", 1'b1, ak)
      tsms_bus_master_i.start();
      tsms_bus_master_i.put({tsms_pkg::DEV_ADDR_RESET, 1'b1}, ak);
      `CHK("read bit", 1'b1, ak)
      tsms_bus_master_i.stop();
      cmd(tsms_pkg::CMD_START_CONV, 1'b0, 8'h00);
      `CHK("conv_run", 1'b1, conv_run)
      n = done_cnt;
      repeat (80) @(posedge clk);
      `CHK("continuous", 1'b1, done_cnt - n >= 5)
      cmd(tsms_pkg::CMD_HALT_CONV, 1'b0, 8'h00);
      `CHK("halt", 1'b0, conv_run)
      n = done_cnt;
      repeat (40) @(posedge clk);
      `CHK("halted", n, done_cnt)
      // unknown first byte and a trailing byte: both acked, nothing changes
      cmd(8'h3C, 1'b1, 8'h01);
      `CHK("ignored byte", 1'b0, conv_run)
      set_mode(1'b1);
      n = done_cnt;
      cmd(tsms_pkg::CMD_START_CONV, 1'b0, 8'h00);
      repeat (80) @(posedge clk);
      `CHK("one shot", 1, done_cnt - n)
      `CHK("one shot idle", 1'b0, conv_run)
      commit();
      cmd(tsms_pkg::CMD_HALT_CONV, 1'b0, 8'h00);
      tsms_bus_master_i.stop();
      set_mode(1'b0);
      cmd(tsms_pkg::CMD_START_CONV, 1'b0, 8'h00);
      n = done_cnt;
      repeat (80) @(posedge clk);
      `CHK("back to continuous", 1'b1, done_cnt - n >= 5)
      commit();
      cmd(tsms_pkg::CMD_HALT_CONV, 1'b0, 8'h00);
      tsms_bus_master_i.stop();
      `CHK("final halt", 1'b0, conv_run)
      `CHK("notes left", 0, exp_q.size())
      close_out();
   end
endmodule // test_thermo_sensor_mode_switch_cmds
`undef CHK
`default_nettype wire
